// *** core/dcbrf_pkg.sv ***
// package: sizes, modes and reset values of the block ram fifo
package dcbrf_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int DEPTH  = 1 << ADDR_W;
    localparam int PTR_W  = ADDR_W + 1;
    localparam int SEL_W  = 2;
    localparam int SYNC_N = 2;

    localparam logic             FULL_RST   = 1'h0;
    localparam logic             AFULL_RST  = 1'h0;
    localparam logic             AEMPTY_RST = 1'h1;
    localparam logic             EMPTY_RST  = 1'h1;
    localparam logic [PTR_W-1:0] PTR_RST    = 5'h00;
    localparam logic [PTR_W-1:0] PTR_ONE    = 5'h01;
    localparam logic [PTR_W-1:0] CNT_EMPTY  = 5'h00;

    typedef enum logic [1:0] {
        mode_single,
        mode_dual,
        mode_fifo
    } dcbrf_mode_t;

    typedef enum logic [1:0] {
        beh_normal,
        beh_write_through,
        beh_read_before_write
    } dcbrf_wbeh_t;
endpackage : dcbrf_pkg

// *** core/dcbrf_top.sv ***
// block ram with single, dual and fifo operation
//==========================================================================
// What this block does
// - normal write behaviour leaves port output unchanged during a write
// - write-through behaviour drives the written data onto that port output
// - read-before-write drives old location contents out while storing new data
// - all three write behaviours work in single and dual port operation
// - fifo write side and read side each have clock, clock enable, enable
// - fifo makes full, almost full, almost empty and empty flags itself
// - full and almost full update only on write clock edges and global fifo reset
// - empty and almost empty update only on read clock edges and global fifo reset
// - thresholds programmable for full, almost full, almost empty; empty is zero
// - global fifo reset clears both pointers and returns all flags
// - two fifo resets exist: global and read pointer only
// - full_in acts as write select bit two, empty_in as read select
// - read pointer reset rewinds reads so stored data reads again
`timescale 1ns/1ps
module dcbrf_top (
    input  wire logic                         clock,
    input  wire logic                         nrst,
    input  wire logic                         clk_en,
    input  wire logic [1:0]                   cfg_mode,
    input  wire logic [1:0]                   wr_behaviour,
    input  wire logic [dcbrf_pkg::ADDR_W-1:0] a_addr,
    input  wire logic [dcbrf_pkg::DATA_W-1:0] a_din,
    input  wire logic                         a_we,
    input  wire logic                         a_ce,
    input  wire logic                         a_cs,
    output wire logic [dcbrf_pkg::DATA_W-1:0] a_dout,
    input  wire logic [dcbrf_pkg::ADDR_W-1:0] b_addr,
    input  wire logic [dcbrf_pkg::DATA_W-1:0] b_din,
    input  wire logic                         b_we,
    input  wire logic                         b_ce,
    input  wire logic                         b_cs,
    output wire logic [dcbrf_pkg::DATA_W-1:0] b_dout,
    input  wire logic                         wr_clock,
    input  wire logic                         wr_clock_enable,
    input  wire logic                         wr_enable,
    input  wire logic [dcbrf_pkg::SEL_W-1:0]  wr_port_select,
    input  wire logic                         full_in,
    input  wire logic [dcbrf_pkg::DATA_W-1:0] wr_data,
    input  wire logic                         rd_clock,
    input  wire logic                         rd_clock_enable,
    input  wire logic                         rd_enable,
    input  wire logic [dcbrf_pkg::SEL_W-1:0]  rd_port_select,
    input  wire logic                         empty_in,
    output wire logic [dcbrf_pkg::DATA_W-1:0] rd_data,
    input  wire logic                         fifo_reset,
    input  wire logic                         rd_pointer_reset,
    input  wire logic [dcbrf_pkg::ADDR_W-1:0] full_level,
    input  wire logic [dcbrf_pkg::ADDR_W-1:0] afull_level,
    input  wire logic [dcbrf_pkg::ADDR_W-1:0] aempty_level,
    output wire logic                         full_flag,
    output wire logic                         almost_full_flag,
    output wire logic                         almost_empty_flag,
    output wire logic                         empty_flag
);
    localparam int AW = dcbrf_pkg::ADDR_W;
    localparam int DW = dcbrf_pkg::DATA_W;
    localparam int PW = dcbrf_pkg::PTR_W;
    localparam int SN = dcbrf_pkg::SYNC_N;

    typedef struct packed {
        logic [SN-1:0]                         wck_s;
        logic                                  wck_d;
        logic [SN-1:0][dcbrf_pkg::SEL_W+2:0]   wen_s;
        logic [SN-1:0][DW-1:0]                 wdat_s;
        logic [SN-1:0]                         rck_s;
        logic                                  rck_d;
        logic [SN-1:0][dcbrf_pkg::SEL_W+2:0]   ren_s;
        logic [dcbrf_pkg::DEPTH-1:0][DW-1:0]   mem;
        logic [PW-1:0]                         wptr;
        logic [PW-1:0]                         rptr;
        logic [SN-1:0][PW-1:0]                 rsync_w;
        logic [SN-1:0][PW-1:0]                 wsync_r;
        logic                                  full;
        logic                                  afull;
        logic                                  aempty;
        logic                                  empty;
        logic [DW-1:0]                         rdat;
        logic [DW-1:0]                         a_out;
        logic [DW-1:0]                         b_out;
    } dcbrf_state_t;

    dcbrf_state_t            q;
    dcbrf_state_t            d;
    dcbrf_pkg::dcbrf_mode_t  mode;
    dcbrf_pkg::dcbrf_wbeh_t  beh;
    logic                    wr_pin_req;
    logic                    rd_pin_req;
    logic                    wr_edge;
    logic                    rd_edge;
    logic [PW-1:0]           w_cnt;
    logic [PW-1:0]           r_cnt;
    logic [PW-1:0]           r_cnt_now;
    logic [DW-1:0]           a_old;

    //======================================================================
    // functions
    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = g;
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        gray2bin = b;
    endfunction : gray2bin

    // port output for one access cycle
    function automatic logic [DW-1:0] port_out(
        input dcbrf_pkg::dcbrf_wbeh_t bh,
        input logic                   we,
        input logic [DW-1:0]          din,
        input logic [DW-1:0]          old,
        input logic [DW-1:0]          cur
    );
        port_out = old;
        if (!we) begin
            port_out = old;
        end else begin
            case (bh)
                dcbrf_pkg::beh_normal: port_out = cur;
                dcbrf_pkg::beh_write_through: port_out = din;
                dcbrf_pkg::beh_read_before_write: port_out = old;
                default: port_out = cur;
            endcase
        end
    endfunction : port_out

    //======================================================================
    // pin qualification
    assign mode = dcbrf_pkg::dcbrf_mode_t'(cfg_mode);
    assign beh  = dcbrf_pkg::dcbrf_wbeh_t'(wr_behaviour);
    // full_in and empty_in as select bit two
    // qualifiers combined only after their second stage, never raw
    assign wr_pin_req = &q.wen_s[SN-1];
    assign rd_pin_req = &q.ren_s[SN-1];
    // edges of the slow port clocks
    assign wr_edge = q.wck_s[SN-1] & ~q.wck_d;
    assign rd_edge = q.rck_s[SN-1] & ~q.rck_d;
    assign a_old   = q.mem[a_addr];
    assign r_cnt_now = PW'(gray2bin(q.wsync_r[SN-1]) - q.rptr);

    //======================================================================
    // next state
    always_comb begin
        d     = q;
        w_cnt = dcbrf_pkg::PTR_RST;
        r_cnt = dcbrf_pkg::PTR_RST;
        if (clk_en) begin
            // data delayed as far as its clock so both line up at the edge
            d.wck_s  = {q.wck_s[0], wr_clock};
            d.wck_d  = q.wck_s[SN-1];
            d.wen_s  = {q.wen_s[0], {wr_clock_enable, wr_enable, full_in, wr_port_select}};
            d.wdat_s = {q.wdat_s[0], wr_data};
            d.rck_s  = {q.rck_s[0], rd_clock};
            d.rck_d  = q.rck_s[SN-1];
            d.ren_s  = {q.ren_s[0], {rd_clock_enable, rd_enable, empty_in, rd_port_select}};
            case (mode)
                dcbrf_pkg::mode_fifo: begin
                    if (wr_edge) begin
                        d.rsync_w = {q.rsync_w[0], bin2gray(q.rptr)};
                        if (wr_pin_req && !q.full) begin
                            d.mem[q.wptr[AW-1:0]] = q.wdat_s[SN-1];
                            d.wptr = PW'(q.wptr + dcbrf_pkg::PTR_ONE);
                        end
                        w_cnt = PW'(d.wptr - gray2bin(d.rsync_w[SN-1]));
                        // full side flags on write edge
                        d.full  = w_cnt >= {1'h0, full_level};
                        d.afull = w_cnt >= {1'h0, afull_level};
                    end
                    if (rd_edge) begin
                        d.wsync_r = {q.wsync_r[0], bin2gray(q.wptr)};
                        if (rd_pin_req && !q.empty) begin
                            d.rdat = q.mem[q.rptr[AW-1:0]];
                            d.rptr = PW'(q.rptr + dcbrf_pkg::PTR_ONE);
                        end
                        r_cnt = PW'(gray2bin(d.wsync_r[SN-1]) - d.rptr);
                        // empty side flags on read edge
                        d.empty  = r_cnt == dcbrf_pkg::CNT_EMPTY;
                        d.aempty = r_cnt <= {1'h0, aempty_level};
                    end
                    if (rd_pointer_reset) begin
                        d.rptr = dcbrf_pkg::PTR_RST;
                    end
                    // global clear of pointers and flags
                    if (fifo_reset) begin
                        d.wptr    = dcbrf_pkg::PTR_RST;
                        d.rptr    = dcbrf_pkg::PTR_RST;
                        d.rsync_w = '0;
                        d.wsync_r = '0;
                        d.full    = dcbrf_pkg::FULL_RST;
                        d.afull   = dcbrf_pkg::AFULL_RST;
                        d.aempty  = dcbrf_pkg::AEMPTY_RST;
                        d.empty   = dcbrf_pkg::EMPTY_RST;
                    end
                end
                dcbrf_pkg::mode_single, dcbrf_pkg::mode_dual: begin
                    // b first so a wins a shared address
                    if (mode == dcbrf_pkg::mode_dual && b_ce && b_cs) begin
                        d.b_out = port_out(beh, b_we, b_din, q.mem[b_addr], q.b_out);
                        if (b_we) begin
                            d.mem[b_addr] = b_din;
                        end
                    end
                    if (a_ce && a_cs) begin
                        d.a_out = port_out(beh, a_we, a_din, a_old, q.a_out);
                        if (a_we) begin
                            d.mem[a_addr] = a_din;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    //======================================================================
    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q        <= '0;
            q.full   <= dcbrf_pkg::FULL_RST;
            q.afull  <= dcbrf_pkg::AFULL_RST;
            q.aempty <= dcbrf_pkg::AEMPTY_RST;
            q.empty  <= dcbrf_pkg::EMPTY_RST;
        end else begin
            q <= d;
        end
    end

    // flags come from the block itself
    assign full_flag         = q.full;
    assign almost_full_flag  = q.afull;
    assign almost_empty_flag = q.aempty;
    assign empty_flag        = q.empty;
    assign rd_data           = q.rdat;
    assign a_dout            = q.a_out;
    assign b_dout            = q.b_out;

    //======================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_a_write;
        clk_en && (mode == dcbrf_pkg::mode_single || mode == dcbrf_pkg::mode_dual)
            && a_ce && a_cs && a_we;
    endsequence
    sequence s_fifo_on;
        clk_en && mode == dcbrf_pkg::mode_fifo && !fifo_reset;
    endsequence

    property p_normal;
        s_a_write and (beh == dcbrf_pkg::beh_normal) |=> $stable(a_dout);
    endproperty
    a_normal: assert property (p_normal) else $error("normal write moved output");

    property p_wthru;
        s_a_write and (beh == dcbrf_pkg::beh_write_through) |=> a_dout == $past(a_din);
    endproperty
    a_wthru: assert property (p_wthru) else $error("write through data missing");

    property p_rbw;
        s_a_write and (beh == dcbrf_pkg::beh_read_before_write)
            |=> a_dout == $past(a_old);
    endproperty
    a_rbw: assert property (p_rbw) else $error("old contents not shown");

    property p_dual_b;
        clk_en && mode == dcbrf_pkg::mode_dual && b_ce && b_cs && b_we
            && beh == dcbrf_pkg::beh_write_through |=> b_dout == $past(b_din);
    endproperty
    a_dual_b: assert property (p_dual_b) else $error("port b write through missing");

    property p_full_hold;
        s_fifo_on and (!wr_edge) |=> $stable(full_flag) && $stable(almost_full_flag);
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full side moved off edge");

    property p_empty_hold;
        s_fifo_on and (!rd_edge) |=> $stable(empty_flag) && $stable(almost_empty_flag);
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("empty side moved off edge");

    property p_empty_val;
        s_fifo_on and rd_edge and (!rd_pointer_reset)
            |=> empty_flag == (r_cnt_now == dcbrf_pkg::CNT_EMPTY);
    endproperty
    a_empty_val: assert property (p_empty_val) else $error("empty flag wrong");

    property p_reset;
        clk_en && mode == dcbrf_pkg::mode_fifo && fifo_reset
            |=> empty_flag && almost_empty_flag && !full_flag && !almost_full_flag
                && q.wptr == dcbrf_pkg::PTR_RST && q.rptr == dcbrf_pkg::PTR_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("fifo reset incomplete");

    property p_rd_pointer_reset;
        s_fifo_on and rd_pointer_reset and (!wr_edge)
            |=> q.rptr == dcbrf_pkg::PTR_RST && $stable(q.wptr);
    endproperty
    a_rd_pointer_reset: assert property (p_rd_pointer_reset) else $error("read pointer reset wrong");

    property p_no_wr_full;
        s_fifo_on and wr_edge and full_flag |=> $stable(q.wptr);
    endproperty
    a_no_wr_full: assert property (p_no_wr_full) else $error("write taken while full");

    property p_no_rd_empty;
        s_fifo_on and rd_edge and empty_flag and (!rd_pointer_reset) |=> $stable(q.rptr);
    endproperty
    a_no_rd_empty: assert property (p_no_rd_empty) else $error("read taken while empty");
endmodule : dcbrf_top

// *** testbench/dcbrf_user_model.sv ***
// user core logic model driving the fifo write and read pins
`timescale 1ns/1ps
module dcbrf_user_model (
    input  wire logic                         clock,
    output logic                              wr_clock,
    output logic                              wr_clock_enable,
    output logic                              wr_enable,
    output logic [dcbrf_pkg::SEL_W-1:0]       wr_port_select,
    output logic                              full_in,
    output logic [dcbrf_pkg::DATA_W-1:0]      wr_data,
    output logic                              rd_clock,
    output logic                              rd_clock_enable,
    output logic                              rd_enable,
    output logic [dcbrf_pkg::SEL_W-1:0]       rd_port_select,
    output logic                              empty_in
);
    //==================================================================
    // idle levels
    initial begin
        {wr_clock, wr_clock_enable, wr_enable, full_in} = 4'h0;
        {rd_clock, rd_clock_enable, rd_enable, empty_in} = 4'h0;
        wr_port_select = 2'h0;
        rd_port_select = 2'h0;
        wr_data        = 8'h00;
    end
    //==================================================================
    // one clock pulse on the write or read side
    // rising edge, active high qualifiers, select bit two
    task automatic pulse(input logic is_wr, input logic en, input logic sel2,
                         input logic [7:0] v);
        // fresh edge first: back to back calls never reassign in one step
        @(posedge clock);
        #1;
        if (is_wr) begin
            {wr_clock_enable, wr_enable, full_in} = {en, en, sel2};
            wr_port_select = 2'h3;
            wr_data        = v;
        end else begin
            {rd_clock_enable, rd_enable, empty_in} = {en, en, sel2};
            rd_port_select = 2'h3;
        end
        // qualifiers held well beyond the synchronizer delay
        repeat (4) @(posedge clock);
        #1;
        if (is_wr) wr_clock = 1'h1; else rd_clock = 1'h1;
        repeat (6) @(posedge clock);
        #1;
        if (is_wr) wr_clock = 1'h0; else rd_clock = 1'h0;
        repeat (6) @(posedge clock);
        #1;
        // released data shows the inverse, never a stale match
        if (is_wr) {wr_enable, wr_data} = {1'h0, ~v}; else rd_enable = 1'h0;
    endtask : pulse
endmodule : dcbrf_user_model

// *** testbench/tb_dual_clock_block_ram_fifo.sv ***
// testbench: ram write behaviours and fifo flags of the block ram fifo
`timescale 1ns/1ps
module tb_dual_clock_block_ram_fifo;
    logic       clock = 1'h0;
    logic       nrst = 1'h0;
    logic       clk_en = 1'h1;
    logic [1:0] cfg_mode = 2'h0;
    logic [1:0] wr_behaviour = 2'h0;
    logic [3:0] a_addr = 4'h0, b_addr = 4'h0;
    logic [7:0] a_din = 8'h00, b_din = 8'h00;
    logic       a_we = 1'h0, a_ce = 1'h0, a_cs = 1'h0;
    logic       b_we = 1'h0, b_ce = 1'h0, b_cs = 1'h0;
    logic       fifo_reset = 1'h0, rd_pointer_reset = 1'h0;
    logic [3:0] full_level = 4'h4, afull_level = 4'h3, aempty_level = 4'h1;
    wire  [7:0] a_dout, b_dout, rd_data, wr_data;
    wire  [1:0] wr_port_select, rd_port_select;
    wire        wr_clock, wr_clock_enable, wr_enable, full_in;
    wire        rd_clock, rd_clock_enable, rd_enable, empty_in;
    wire        full_flag, almost_full_flag, almost_empty_flag, empty_flag;
    int         errors = 0;
    int         num_checks = 0;

    always #4 clock = ~clock;

    dcbrf_top dcbrf_top_inst (.clock(clock), .nrst(nrst), .clk_en(clk_en),
        .cfg_mode(cfg_mode), .wr_behaviour(wr_behaviour), .a_addr(a_addr), .a_din(a_din),
        .a_we(a_we), .a_ce(a_ce), .a_cs(a_cs), .a_dout(a_dout), .b_addr(b_addr),
        .b_din(b_din), .b_we(b_we), .b_ce(b_ce), .b_cs(b_cs), .b_dout(b_dout),
        .wr_clock(wr_clock), .wr_clock_enable(wr_clock_enable), .wr_enable(wr_enable),
        .wr_port_select(wr_port_select), .full_in(full_in), .wr_data(wr_data),
        .rd_clock(rd_clock), .rd_clock_enable(rd_clock_enable), .rd_enable(rd_enable),
        .rd_port_select(rd_port_select), .empty_in(empty_in), .rd_data(rd_data),
        .fifo_reset(fifo_reset), .rd_pointer_reset(rd_pointer_reset),
        .full_level(full_level), .afull_level(afull_level), .aempty_level(aempty_level),
        .full_flag(full_flag), .almost_full_flag(almost_full_flag),
        .almost_empty_flag(almost_empty_flag), .empty_flag(empty_flag));

    dcbrf_user_model dcbrf_user_model_inst (.clock(clock), .wr_clock(wr_clock),
        .wr_clock_enable(wr_clock_enable), .wr_enable(wr_enable),
        .wr_port_select(wr_port_select), .full_in(full_in), .wr_data(wr_data),
        .rd_clock(rd_clock), .rd_clock_enable(rd_clock_enable), .rd_enable(rd_enable),
        .rd_port_select(rd_port_select), .empty_in(empty_in));

    //==================================================================
    // compares and verdict
    task automatic chk_data(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_data
    task automatic chk_flag(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag
    task automatic flags(input logic e, input logic ae, input logic af, input logic f);
        chk_flag("empty_flag", e, empty_flag);
        chk_flag("almost_empty_flag", ae, almost_empty_flag);
        chk_flag("almost_full_flag", af, almost_full_flag);
        chk_flag("full_flag", f, full_flag);
    endtask : flags
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    //==================================================================
    // one ram access, dout read back after it settles
    task automatic ram_op(input logic pb, input logic we, input logic [3:0] ad,
                          input logic [7:0] d);
        @(posedge clock);
        #1;
        if (pb) {b_ce, b_cs, b_we, b_addr, b_din} = {2'h3, we, ad, d};
        else    {a_ce, a_cs, a_we, a_addr, a_din} = {2'h3, we, ad, d};
        @(posedge clock);
        #1;
        {a_ce, a_we, b_ce, b_we, a_din, b_din} = {4'h0, ~d, ~d};
        @(posedge clock);
        #1;
    endtask : ram_op
    task automatic push(input logic [7:0] v);
        dcbrf_user_model_inst.pulse(1'h1, 1'h1, 1'h1, v);
    endtask : push
    task automatic pop();
        dcbrf_user_model_inst.pulse(1'h0, 1'h1, 1'h1, 8'h00);
    endtask : pop
    task automatic tick();
        dcbrf_user_model_inst.pulse(1'h0, 1'h0, 1'h1, 8'h00);
    endtask : tick
    task automatic sync_pulse(input logic rp);
        @(posedge clock);
        #1;
        if (rp) rd_pointer_reset = 1'h1; else fifo_reset = 1'h1;
        @(posedge clock);
        #1;
        {rd_pointer_reset, fifo_reset} = 2'h0;
        @(posedge clock);
        #1;
    endtask : sync_pulse

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        finish_test();
    end

    initial begin
        logic [7:0] exp;
        repeat (12) @(posedge clock);
        flags(1'h1, 1'h1, 1'h0, 1'h0);
        #1 nrst = 1'h1;
        // each behaviour on single and dual port
        for (int p = 0; p < 2; p++) begin
            cfg_mode = 2'(p);
            for (int b = 0; b < 3; b++) begin
                wr_behaviour = 2'(b);
                ram_op(p[0], 1'h1, 4'h5, 8'h10 + 8'(b));
                ram_op(p[0], 1'h1, 4'h6, 8'h40 + 8'(b));
                ram_op(p[0], 1'h0, 4'h6, 8'h00);
                ram_op(p[0], 1'h1, 4'h5, 8'h80 + 8'(b));
                exp = (b == 0) ? 8'h40 + 8'(b) : (b == 1) ? 8'h80 + 8'(b) : 8'h10 + 8'(b);
                chk_data("dout on write", exp, p ? b_dout : a_dout);
                ram_op(p[0], 1'h0, 4'h5, 8'h00);
                chk_data("dout on read", 8'h80 + 8'(b), p ? b_dout : a_dout);
            end
        end
        // clock enable low and idle mode store nothing
        wr_behaviour = 2'h1;
        clk_en = 1'h0;
        ram_op(1'h1, 1'h1, 4'h5, 8'h77);
        chk_data("b_dout frozen", 8'h82, b_dout);
        clk_en = 1'h1;
        cfg_mode = 2'h3;
        ram_op(1'h1, 1'h1, 4'h5, 8'h99);
        cfg_mode = 2'h1;
        ram_op(1'h1, 1'h0, 4'h5, 8'h00);
        chk_data("b_dout after idle writes", 8'h82, b_dout);
        $display("test ram behaviours done");
        cfg_mode = 2'h2;
        sync_pulse(1'h0);
        // thresholds on write side, write refused when full
        for (int i = 0; i < 4; i++) begin
            push(8'ha0 + 8'(i));
            chk_flag("almost_full_flag", i >= 2, almost_full_flag);
            chk_flag("full_flag", i >= 3, full_flag);
        end
        push(8'hee);
        tick();
        tick();
        flags(1'h0, 1'h0, 1'h1, 1'h1);
        for (int i = 0; i < 4; i++) begin
            pop();
            chk_data("rd_data", 8'ha0 + 8'(i), rd_data);
            chk_flag("almost_empty_flag", i >= 2, almost_empty_flag);
            chk_flag("empty_flag", i == 3, empty_flag);
        end
        pop();
        chk_data("rd_data after refused read", 8'ha3, rd_data);
        $display("test fifo flags done");
        // read pointer rewinds, data reads again
        sync_pulse(1'h1);
        tick();
        chk_flag("empty_flag", 1'h0, empty_flag);
        pop();
        chk_data("rd_data reread", 8'ha0, rd_data);
        sync_pulse(1'h0);
        flags(1'h1, 1'h1, 1'h0, 1'h0);
        $display("test fifo resets done");
        // select bit two gates write and read
        dcbrf_user_model_inst.pulse(1'h1, 1'h1, 1'h0, 8'h55);
        tick();
        tick();
        chk_flag("empty_flag", 1'h1, empty_flag);
        push(8'h66);
        tick();
        tick();
        dcbrf_user_model_inst.pulse(1'h0, 1'h1, 1'h0, 8'h00);
        chk_flag("empty_flag", 1'h0, empty_flag);
        pop();
        chk_data("rd_data", 8'h66, rd_data);
        chk_flag("empty_flag", 1'h1, empty_flag);
        $display("test select bits done");
        finish_test();
    end
endmodule : tb_dual_clock_block_ram_fifo
